// ==== rtl/efc_ctrl.sv ====
`timescale 1ns/100ps
`include "efc_consts.svh"

module efc_ctrl import efc_pkg::*; #(
	parameter int NVS_CYCLES = `EFC_NVS_CYC
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// AXI4-Lite write
	input wire logic [3:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// AXI4-Lite read
	input wire logic [3:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// CPU access to the array
	input wire logic arr_wr_in,
	input wire logic [15:0] arr_addr_in,
	input wire logic [7:0] arr_wdata_in,
	input wire logic [7:0] cell_programmed_in,
	output logic [7:0] arr_rdata_out,
	// Array macro control
	output logic high_voltage_out,
	output logic page_erase_out,
	output logic mass_erase_out,
	output logic [15:0] op_addr_out,
	output logic [7:0] prog_data_out,
	output logic prog_strobe_out
);

	// Start of the protected range; 17'h10000 means none
	function automatic logic [16:0] prot_start(input logic [7:0] v);
		logic [16:0] s;
		s = {1'b0, v[7:1], 9'h000};
		// Protect decode
		// RQ19 whole array / option byte and up
		if (v <= `EFC_PROT_ALL_MAX)
			s = 17'h00000;
		else if (v == `EFC_PROT_NONE)
			// RQ18 all ones disables
			s = 17'h10000;
		else if (v >= `EFC_PROT_OPT_MIN)
			s = {1'b0, `EFC_OPTION_ADDR};
		// RQ17 bits 7..1 to 15..9 apply otherwise
		return s;
	endfunction

	function automatic logic in_array(input logic [15:0] a);
		// RQ21 user, vector and option areas
		return (a >= `EFC_USER_LO && a <= `EFC_USER_HI) ||
			(a >= `EFC_OPTION_ADDR);
	endfunction

	logic [7:0] ctrl_r;
	logic [7:0] prot_r;
	logic [15:0] lat_addr_r;
	logic [7:0] lat_data_r;
	logic latched_r;
	logic [7:0] nvs_cnt_r;
	logic [3:0] awaddr_r;
	logic aw_full_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic w_full_r;
	efc_mode_t mode;
	logic program_select, ers, mass, hv;
	logic wr_go, wr_map, ctrl_wr, prot_wr;
	logic [7:0] ctrl_nxt;
	logic addr_prot, hv_ok;

	assign program_select = ctrl_r[`EFC_BIT_PGM];
	assign ers = ctrl_r[`EFC_BIT_ERASE];
	assign mass = ctrl_r[`EFC_BIT_MASS];
	assign hv = ctrl_r[`EFC_BIT_HV];

	always_comb begin
		// RQ2 mass picks erase kind
		if (ers && mass)
			mode = EFC_MODE_MASS;
		else if (ers)
			mode = EFC_MODE_PAGE;
		else if (program_select)
			mode = EFC_MODE_PROG;
		else
			mode = EFC_MODE_IDLE;
	end

	// Write address and data may come in either order
	assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid_out;
	assign wr_map = awaddr_r[1:0] == 2'b00 && (awaddr_r == `EFC_OFF_CTRL ||
		awaddr_r == `EFC_OFF_PROT);
	assign ctrl_wr = wr_go && awaddr_r == `EFC_OFF_CTRL && wstrb_r[0];
	assign prot_wr = wr_go && awaddr_r == `EFC_OFF_PROT && wstrb_r[0];

	always_comb begin
		// RQ16 protected up to the top
		addr_prot = {1'b0, lat_addr_r} >= prot_start(prot_r);
		unique case (mode)
			// RQ20 mass erase blocked only by the register
			EFC_MODE_MASS: addr_prot = prot_r != `EFC_PROT_NONE;
			// RQ6 vectors and option byte never page-erased
			EFC_MODE_PAGE,
			EFC_MODE_PROG: addr_prot = addr_prot ||
				lat_addr_r >= `EFC_OPTION_ADDR;
			EFC_MODE_IDLE: addr_prot = 1'b1;
		endcase
		// RQ1 selected, latch write done and settle time past
		// RQ15 refuse on protected location
		hv_ok = latched_r && nvs_cnt_r == 8'(NVS_CYCLES) && !addr_prot;
	end

	always_comb begin
		ctrl_nxt = {4'h0, s_axi_wdata_in[3:0] & 4'h0} | {4'h0,
			wdata_r[3:0]};
		// RQ3 both selects at once leaves them unchanged
		if (wdata_r[`EFC_BIT_PGM] && wdata_r[`EFC_BIT_ERASE]) begin
			ctrl_nxt[`EFC_BIT_PGM] = program_select;
			ctrl_nxt[`EFC_BIT_ERASE] = ers;
		end
		// RQ3 selecting one while the other is set is refused too
		if ((wdata_r[`EFC_BIT_PGM] && ers) ||
			(wdata_r[`EFC_BIT_ERASE] && program_select)) begin
			ctrl_nxt[`EFC_BIT_PGM] = program_select;
			ctrl_nxt[`EFC_BIT_ERASE] = ers;
		end
		// RQ1 setting high voltage needs an already-armed sequence
		if (wdata_r[`EFC_BIT_HV] && !hv && !hv_ok)
			ctrl_nxt[`EFC_BIT_HV] = 1'b0;
	end

	// Control register
	always_ff @(posedge clock_in) begin
		// RQ22 cleared at reset
		if (sys_rst_in)
			ctrl_r <= `EFC_CTRL_RST;
		else if (ctrl_wr)
			ctrl_r <= ctrl_nxt;
	end

	// Protect register, unprotected after reset
	always_ff @(posedge clock_in) begin
		if (sys_rst_in)
			prot_r <= `EFC_PROT_RST;
		else if (prot_wr)
			prot_r <= s_axi_wdata_in[7:0] & 8'h00 | wdata_r[7:0];
	end

	// Address/data latch and settle timer
	// Any return to idle drops the latch, so each sequence needs its own write
	always_ff @(posedge clock_in) begin
		if (sys_rst_in || mode == EFC_MODE_IDLE) begin
			latched_r <= 1'b0;
			lat_addr_r <= 16'h0000;
			lat_data_r <= 8'h00;
			nvs_cnt_r <= 8'h00;
		end else begin
			if (latched_r && nvs_cnt_r != 8'(NVS_CYCLES))
				nvs_cnt_r <= nvs_cnt_r + 8'h01;
			// RQ9 capture array write while selected
			if (arr_wr_in && in_array(arr_addr_in) && !hv) begin
				latched_r <= 1'b1;
				lat_addr_r <= arr_addr_in;
				lat_data_r <= arr_wdata_in;
				nvs_cnt_r <= 8'h00;
			end
		end
	end

	// Outputs to the array macro
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			high_voltage_out <= 1'b0;
			page_erase_out <= 1'b0;
			mass_erase_out <= 1'b0;
			op_addr_out <= 16'h0000;
			prog_data_out <= 8'h00;
			prog_strobe_out <= 1'b0;
		end else begin
			// Erase levels lag the control bits by one cycle
			high_voltage_out <= hv;
			page_erase_out <= hv && mode == EFC_MODE_PAGE;
			mass_erase_out <= hv && mode == EFC_MODE_MASS;
			prog_strobe_out <= 1'b0;
			if (mode == EFC_MODE_PAGE)
				// RQ5 page aligned to 512 bytes
				op_addr_out <= {lat_addr_r[15:`EFC_PAGE_BITS],
					`EFC_PAGE_BITS'(0)};
			else if (mode != EFC_MODE_PROG)
				op_addr_out <= lat_addr_r;
			// RQ10 bytes only within the latched 64-byte row
			if (mode == EFC_MODE_PROG && hv && arr_wr_in &&
				arr_addr_in[15:`EFC_ROW_BITS] ==
				lat_addr_r[15:`EFC_ROW_BITS]) begin
				op_addr_out <= arr_addr_in;
				prog_data_out <= arr_wdata_in;
				prog_strobe_out <= 1'b1;
			end else if (mode == EFC_MODE_PROG && !hv) begin
				op_addr_out <= lat_addr_r;
				prog_data_out <= lat_data_r;
			end
		end
	end

	// Array read path
	always_ff @(posedge clock_in) begin
		// RQ4 erased reads one
		if (sys_rst_in)
			arr_rdata_out <= 8'hff;
		else
			arr_rdata_out <= ~cell_programmed_in;
	end

	// AXI4-Lite write channel
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awaddr_r <= 4'h0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `EFC_RESP_OK;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_full_r <= 1'b1;
				awaddr_r <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_full_r <= 1'b1;
				wdata_r <= s_axi_wdata_in;
				wstrb_r <= s_axi_wstrb_in;
			end
			if (wr_go) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= wr_map ? `EFC_RESP_OK : `EFC_RESP_ERR;
			end else if (s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
		end
	end

	// Readies pulse for one cycle; a held valid meets the next pulse
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
		end else begin
			s_axi_awready_out <= !aw_full_r && !s_axi_awready_out &&
				!s_axi_bvalid_out;
			s_axi_wready_out <= !w_full_r && !s_axi_wready_out &&
				!s_axi_bvalid_out;
			if (s_axi_awvalid_in && s_axi_awready_out)
				s_axi_awready_out <= 1'b0;
			if (s_axi_wvalid_in && s_axi_wready_out)
				s_axi_wready_out <= 1'b0;
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= `EFC_RESP_OK;
		end else begin
			s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out;
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out <= 1'b1;
				s_axi_rresp_out <= `EFC_RESP_OK;
				unique case (s_axi_araddr_in)
					`EFC_OFF_CTRL: s_axi_rdata_out <= {24'h0, ctrl_r};
					`EFC_OFF_PROT: s_axi_rdata_out <= {24'h0, prot_r};
					`EFC_OFF_LATCH: s_axi_rdata_out <= {8'h0,
						lat_data_r, lat_addr_r};
					// Status word: hv_ok, latched, protected, mode
					`EFC_OFF_STAT: s_axi_rdata_out <= {27'h0, hv_ok,
						latched_r, addr_prot, mode};
					default: begin
						s_axi_rdata_out <= 32'h0000_0000;
						s_axi_rresp_out <= `EFC_RESP_ERR;
					end
				endcase
			end else if (s_axi_rvalid_out && s_axi_rready_in)
				s_axi_rvalid_out <= 1'b0;
		end
	end

endmodule

// ==== rtl/efc_consts.svh ====
// How it works
// RQ1 - High voltage sets only with program or erase already selected, sequence followed.
// RQ2 - With erase selected, mass bit picks whole-array or single-page erase.
// RQ3 - Erase and program selects never both one; such a write fails.
// RQ4 - Array reads give one for erased bits, zero for programmed bits.
// RQ5 - Smallest erase unit is a 512-byte page on a 512-byte boundary.
// RQ6 - Page erase never clears the 48-byte vector area.
// RQ7 - Software page erase order: select, write, 5us, HV, 20ms, deselect, 5us, HV off.
// RQ8 - Software mass erase order: select, write, 5us, HV, 200ms, deselect, 100us.
// RQ9 - With program selected, array write address and data are captured.
// RQ10 - Programming acts on a 64-byte row on a 64-byte boundary.
// RQ11 - Software programs row: select, write, 5us, HV, 10us, bytes 20-40us each.
// RQ12 - Gaps between byte writes never exceed the maximum programming time.
// RQ13 - Sequence code never runs from the flash array itself.
// RQ14 - Sequence steps stay in order; unrelated work may come between.
// RQ15 - High voltage is refused when the addressed location is protected.
// RQ16 - Protected range runs from the derived start address to the top.
// RQ17 - Protect bits 7..1 give address bits 15..9; lower nine bits zero.
// RQ18 - Protect lsb matters only for all ones, which disables protection.
// RQ19 - Values 00..09 protect everything; FC..FE protect from FFCF upward.
// RQ20 - Option byte and vectors always protected; only mass erase clears them.
// RQ21 - User array 62,368 bytes, then 48 vector bytes and one option byte.
// RQ22 - All control bits come out of reset cleared.
`ifndef EFC_CONSTS_SVH
`define EFC_CONSTS_SVH

`define EFC_OFF_CTRL 4'h0
`define EFC_OFF_PROT 4'h4
`define EFC_OFF_LATCH 4'h8
`define EFC_OFF_STAT 4'hc

`define EFC_BIT_PGM 0
`define EFC_BIT_ERASE 1
`define EFC_BIT_MASS 2
`define EFC_BIT_HV 3

`define EFC_CTRL_RST 8'h00
`define EFC_PROT_RST 8'hff

`define EFC_USER_LO 16'h0860
`define EFC_USER_HI 16'hfbff
`define EFC_OPTION_ADDR 16'hffcf
`define EFC_PROT_ALL_MAX 8'h09
`define EFC_PROT_OPT_MIN 8'hfc
`define EFC_PROT_NONE 8'hff
`define EFC_PAGE_BITS 9
`define EFC_ROW_BITS 6

`define EFC_CLK_MHZ 25
`define EFC_T_NVS_US 5
`define EFC_NVS_CYC (`EFC_T_NVS_US * `EFC_CLK_MHZ)

`define EFC_RESP_OK 2'b00
`define EFC_RESP_ERR 2'b10

`endif

// ==== rtl/efc_pkg.sv ====
package efc_pkg;
	typedef enum logic [1:0] {
		EFC_MODE_IDLE,
		EFC_MODE_PROG,
		EFC_MODE_PAGE,
		EFC_MODE_MASS
	} efc_mode_t;
endpackage

// ==== bench/efc_ctrl_properties.sv ====
`timescale 1ns/100ps
module efc_ctrl_props (
	// Clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// Watched ports
	input wire logic s_axi_bvalid_out,
	input wire logic arr_wr_in,
	input wire logic [15:0] arr_addr_in,
	input wire logic [7:0] arr_wdata_in,
	input wire logic [7:0] cell_programmed_in,
	input wire logic [7:0] arr_rdata_out,
	input wire logic high_voltage_out,
	input wire logic page_erase_out,
	input wire logic mass_erase_out,
	input wire logic [15:0] op_addr_out,
	input wire logic [7:0] prog_data_out,
	input wire logic prog_strobe_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	a_erase_excl: assert property (!(page_erase_out && mass_erase_out))
		else $error("page and mass erase together");
	a_erase_hv: assert property (page_erase_out || mass_erase_out |->
		high_voltage_out) else $error("erase without high voltage");
	a_read_inv: assert property (!$past(sys_rst_in) |->
		arr_rdata_out == ~$past(cell_programmed_in)) else $error("read level");
	a_page_align: assert property (page_erase_out |->
		op_addr_out[8:0] == 9'h0) else $error("page base unaligned");
	a_strobe_src: assert property (prog_strobe_out |-> $past(arr_wr_in) &&
		op_addr_out == $past(arr_addr_in) &&
		prog_data_out == $past(arr_wdata_in)) else $error("strobe source");
	a_strobe_hv: assert property (prog_strobe_out |-> high_voltage_out &&
		!page_erase_out && !mass_erase_out) else $error("strobe mode");
	a_strobe_top: assert property (prog_strobe_out |->
		op_addr_out < 16'hffcf) else $error("vector area programmed");
	a_hv_cause: assert property ($rose(high_voltage_out) |->
		$past(s_axi_bvalid_out)) else $error("high voltage without write");
	a_reset_off: assert property (disable iff (1'b0) sys_rst_in |=>
		!high_voltage_out && !prog_strobe_out && !mass_erase_out)
		else $error("active after reset");
	c_page: cover property (page_erase_out);
	c_mass: cover property (mass_erase_out);
	c_prog: cover property (prog_strobe_out);
endmodule

bind efc_ctrl efc_ctrl_props u_props (.*);

// ==== bench/efc_ctrl_tb.sv ====
`timescale 1ns/100ps
module efc_ctrl_tb;
	logic clock_in = 0, sys_rst_in = 1, arr_wr_in = 0;
	logic [3:0] s_axi_awaddr_in = 0, s_axi_wstrb_in = 4'h1;
	logic [3:0] s_axi_araddr_in = 0;
	logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
	logic s_axi_arvalid_in = 0, s_axi_rready_in = 0;
	logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out;
	logic [15:0] arr_addr_in = 0, op_addr_out, a, b;
	logic [7:0] arr_wdata_in = 0, cell_programmed_in = 0, arr_rdata_out;
	logic [7:0] prog_data_out, p, d;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic s_axi_arready_out, s_axi_rvalid_out, high_voltage_out;
	logic page_erase_out, mass_erase_out, prog_strobe_out;
	logic [7:0] pv [7] = '{8'h00, 8'h09, 8'h0a, 8'h7f, 8'hfc, 8'hfe, 8'hff};
	int err_count = 0, n_tests = 0, seed = 32'ha256, i;

	always #20 clock_in = ~clock_in;
	// Cheap changing pattern keeps the cell inputs moving every cycle
	always @(posedge clock_in)
		cell_programmed_in <= cell_programmed_in * 8'h05 + 8'h3b;
	efc_ctrl #(.NVS_CYCLES(4)) dut (.*);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] ad, input logic [7:0] v,
		input logic [1:0] r = 2'b00);
		@(posedge clock_in);
		s_axi_awaddr_in <= ad;
		s_axi_wdata_in <= {24'h0, v};
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(posedge clock_in);
			if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while (s_axi_bvalid_out !== 1'b1);
		s_axi_bready_in <= 1'b0;
		chk(s_axi_bresp_out, r);
	endtask
	task automatic rd(input logic [3:0] ad, input logic [31:0] e,
		input logic [1:0] r = 2'b00);
		@(posedge clock_in);
		s_axi_araddr_in <= ad;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			@(posedge clock_in);
			if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
		end while (s_axi_rvalid_out !== 1'b1);
		s_axi_rready_in <= 1'b0;
		chk(s_axi_rdata_out, e);
		chk(s_axi_rresp_out, r);
	endtask
	task automatic aw(input logic [15:0] ad, input logic [7:0] v);
		@(posedge clock_in);
		arr_wr_in <= 1'b1;
		arr_addr_in <= ad;
		arr_wdata_in <= v;
		@(posedge clock_in);
		arr_wr_in <= 1'b0;
		#1;
	endtask
	// steps in order, from the bus
	task automatic arm(input logic [7:0] sel, input logic [15:0] ad);
		wr(4'h0, sel);
		aw(ad, 8'h00);
		repeat (6) @(posedge clock_in);
		wr(4'h0, sel | 8'h08);
	endtask
	function automatic logic [15:0] ua();
		return 16'h0860 + 16'($unsigned($random(seed)) % 62368);
	endfunction
	function automatic logic prot(input logic [7:0] pr, input logic [15:0] ad);
		if (ad >= 16'hffcf || pr <= 8'h09) return 1'b1;
		if (pr >= 8'hfc) return 1'b0;
		return ad >= {pr[7:1], 9'h0};
	endfunction
	task final_report;
		if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		rd(4'h0, 0);
		rd(4'h4, 8'hff);
		wr(4'h0, 8'h03);
		rd(4'h0, 0);
		wr(4'h0, 8'h01);
		wr(4'h0, 8'h02);
		rd(4'h0, 1);
		wr(4'h0, 8'h00);
		// no HV before a latched write
		wr(4'h0, 8'h02);
		wr(4'h0, 8'h0a);
		rd(4'h0, 8'h02);
		wr(4'h0, 8'h00);
		for (i = 0; i < 2; i++) begin
			a = ua();
			arm(i ? 8'h06 : 8'h02, a);
			#1;
			chk(page_erase_out, i == 0);
			chk(mass_erase_out, i == 1);
			if (i == 0) chk(op_addr_out, {a[15:9], 9'h0});
			wr(4'h0, 8'h08);
			wr(4'h0, 8'h00);
		end
		// one row, then a byte outside it
		a = (16'h0880 + 16'($unsigned($random(seed)) % 16'hf000)) & 16'hffc0;
		arm(8'h01, a);
		for (i = 0; i < 5; i++) begin
			d = 8'($random(seed));
			b = (i < 4) ? (a | (16'($random(seed)) & 16'h3f)) : a + 16'h40;
			aw(b, d);
			chk(prog_strobe_out, i < 4);
			if (i < 4) chk({op_addr_out, prog_data_out}, {b, d});
		end
		rd(4'h8, {16'h0000, a});
		wr(4'h0, 8'h08);
		wr(4'h0, 8'h00);
		for (i = 0; i < 12; i++) begin
			p = (i < 7) ? pv[i] : 8'($random(seed));
			a = (i == 6) ? 16'hffd0 : ua();
			wr(4'h4, p);
			rd(4'h4, p);
			arm(8'h01, a);
			rd(4'h0, prot(p, a) ? 8'h01 : 8'h09);
			wr(4'h0, 8'h00);
		end
		wr(4'h8, 8'h55, 2'b10);
		rd(4'h2, 0, 2'b10);
		rd(4'h4, p);
		final_report();
	end

	initial begin
		repeat (20000) @(posedge clock_in);
		err_count++;
		final_report();
	end
endmodule
